// File: rtl/cam_alarm_top.sv
// alarm masking, alarm output and status readback registers
`timescale 1ns/100ps
`default_nettype none
`include "cam_params.svh"

module cam_alarm_top (
  input wire logic clk_sys_in,                        // register clock, 250 MHz
  input wire logic reset_in,                          // async reset, active high
  input wire cam_pkg::cam_status_t status_in,         // status conditions
  input wire cam_pkg::cam_reg_req_t reg_req_in,       // register read or write
  input wire logic sticky_clear_in,                   // clear event for sticky bits
  output logic [7:0] reg_rdata_out,                   // read data, cycle after read
  output logic alarm_out                              // alarm output, active high
);

  cam_pkg::cam_state_t st;
  cam_pkg::cam_state_t next_st;
  logic il_near;
  logic ol_near;
  logic [7:0] il_live;
  logic [7:0] gen_live;
  logic [`CAM_STICKY_W-1:0] sticky_set;
  logic [`CAM_STICKY_W-1:0] sticky;
  logic alarm_cause;
  logic [23:0] id_value;

  // near lock once the lock counter reaches a sixteenth of its limit
  function automatic logic near_lock(input logic [15:0] count, input logic [15:0] limit);
    near_lock = (count >= (limit >> `CAM_NEAR_SHIFT));
  endfunction : near_lock

  // any enabled condition raises the alarm
  function automatic logic masked_any(input logic [7:0] cond, input logic [7:0] mask);
    masked_any = |(cond & mask);
  endfunction : masked_any

  assign id_value = `CAM_ID_VALUE; // arbitrary value, not a real part code

  // near lock detection for both loops
  assign il_near = near_lock(status_in.il_lock_count, status_in.il_lock_limit);
  assign ol_near = near_lock(status_in.ol_lock_count, status_in.ol_lock_limit);

  // live input loop status: near, acquiring, locked, holdover, loss per input
  assign il_live = {il_near, status_in.il_acquiring, status_in.il_locked,
                    status_in.il_holdover, status_in.los};

  // live general status, reserved bits read as zero
  assign gen_live = {3'h0,
                     (status_in.ol_locked | status_in.ol_disabled) & ~st.synced,
                     status_in.il_locked & status_in.ol_locked,
                     status_in.sysref_valid,
                     ~st.synced,
                     ol_near};

  // events recorded by the sticky register
  assign sticky_set = {status_in.ol_acquiring, status_in.il_acquiring,
                       status_in.il_holdover, status_in.los};

  // masked alarm sources; reserved general mask bits take no part
  assign alarm_cause = masked_any(il_live, st.il_mask) |
                       masked_any(gen_live, {3'h0, st.gen_mask[4:0]});

  cam_sticky u_sticky (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .set_in(sticky_set),
    .clear_in(sticky_clear_in),
    .sticky_out(sticky)
  );

  // next state: mask writes, sync record, alarm and read data
  always_comb begin
    next_st = st;
    if (reg_req_in.wr && reg_req_in.addr == `CAM_ADDR_IL_MASK) begin
      next_st.il_mask = reg_req_in.wdata;
    end
    if (reg_req_in.wr && reg_req_in.addr == `CAM_ADDR_GEN_MASK) begin
      next_st.gen_mask = reg_req_in.wdata;
    end
    if (status_in.sync_pin_pulse || status_in.sync_spi_request) begin
      next_st.synced = 1'b1;
    end
    next_st.alarm = alarm_cause;
    if (reg_req_in.rd) begin
      case (reg_req_in.addr)
        `CAM_ADDR_IL_MASK: begin
          next_st.rdata = st.il_mask;
        end
        `CAM_ADDR_GEN_MASK: begin
          next_st.rdata = st.gen_mask;
        end
        `CAM_ADDR_ID_LOW: begin
          next_st.rdata = id_value[7:0];
        end
        `CAM_ADDR_ID_MID: begin
          next_st.rdata = id_value[15:8];
        end
        `CAM_ADDR_ID_HIGH: begin
          next_st.rdata = id_value[23:16];
        end
        `CAM_ADDR_ALARM: begin
          next_st.rdata = {7'h00, st.alarm};
        end
        `CAM_ADDR_IL_LIVE: begin
          next_st.rdata = il_live;
        end
        `CAM_ADDR_GEN_LIVE: begin
          next_st.rdata = gen_live;
        end
        `CAM_ADDR_STICKY: begin
          next_st.rdata = {1'b0, sticky};
        end
        default: begin
          next_st.rdata = 8'h00; // spare and unmapped addresses
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      st.il_mask <= `CAM_RST_MASK;
      st.gen_mask <= `CAM_RST_MASK;
      st.synced <= 1'b0;
      st.alarm <= 1'b0;
      st.rdata <= 8'h00;
    end else begin
      st <= next_st;
    end
  end

  // outputs come straight from flip-flops
  assign reg_rdata_out = st.rdata;
  assign alarm_out = st.alarm;

  // checks on the alarm path and the readback registers
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (reset_in);

  il_loop_gate_a: assert property (
    (il_live[7:4] & st.il_mask[7:4]) != 4'h0 |=> alarm_out)
    else $error("enabled input loop condition did not raise alarm");

  los_gate_a: assert property (
    (status_in.los & st.il_mask[3:0]) != 4'h0 |=> alarm_out)
    else $error("enabled loss of signal did not raise alarm");

  gen_gate_a: assert property (
    (gen_live[4:0] & st.gen_mask[4:0]) != 5'h00 |=> alarm_out)
    else $error("enabled general condition did not raise alarm");

  alarm_quiet_a: assert property (
    (il_live & st.il_mask) == 8'h00 && (gen_live[4:0] & st.gen_mask[4:0]) == 5'h00
    |=> !alarm_out)
    else $error("alarm raised with no enabled condition");

  alarm_readback_a: assert property (
    reg_req_in.rd && reg_req_in.addr == `CAM_ADDR_ALARM
    |=> reg_rdata_out == {7'h00, $past(alarm_out)})
    else $error("alarm readback differs from alarm output");

  il_live_read_a: assert property (
    reg_req_in.rd && reg_req_in.addr == `CAM_ADDR_IL_LIVE
    |=> reg_rdata_out[3:0] == $past(status_in.los)
        && reg_rdata_out[5] == $past(status_in.il_locked))
    else $error("input loop status readback wrong");

  sync_request_a: assert property (
    status_in.ol_disabled && !st.synced |-> gen_live[4])
    else $error("sync request status not shown");

  both_lock_a: assert property (
    gen_live[3] |-> status_in.il_locked && status_in.ol_locked)
    else $error("combined lock shown while a loop is unlocked");

  sysref_valid_a: assert property (
    reg_req_in.rd && reg_req_in.addr == `CAM_ADDR_GEN_LIVE
    |=> reg_rdata_out[2] == $past(status_in.sysref_valid))
    else $error("sysref valid readback wrong");

  synced_hold_a: assert property (
    status_in.sync_pin_pulse || status_in.sync_spi_request |=> !gen_live[1] [*8])
    else $error("sync status did not stay cleared after sync");

  ol_near_a: assert property (
    status_in.ol_lock_limit == 16'h0100 && status_in.ol_lock_count == 16'h0010
    |-> gen_live[0])
    else $error("output loop near lock not declared at a sixteenth");

  sticky_set_a: assert property (
    sticky_set != '0 |=> (sticky & $past(sticky_set)) == $past(sticky_set))
    else $error("sticky bit did not latch an event");

  sticky_clear_a: assert property (
    sticky_clear_in && sticky_set == '0 |=> sticky == '0)
    else $error("sticky bits not zeroed by clear");

  ident_read_a: assert property (
    reg_req_in.rd && reg_req_in.addr == `CAM_ADDR_ID_HIGH
    |=> reg_rdata_out == id_value[23:16])
    else $error("identification high byte wrong");

  // main scenarios
  alarm_rise_c: cover property (!alarm_out ##1 alarm_out);
  sync_seen_c: cover property (!st.synced ##1 st.synced);
  sticky_race_c: cover property (sticky_clear_in && sticky_set != '0);
  mask_write_c: cover property (reg_req_in.wr && reg_req_in.addr == `CAM_ADDR_GEN_MASK);

endmodule : cam_alarm_top
`default_nettype wire

// File: rtl/cam_params.svh
// offsets, field widths and reset values of the clock alarm mask and readback block
`ifndef CAM_PARAMS_SVH
`define CAM_PARAMS_SVH

`define CAM_ADDR_W 12
`define CAM_ADDR_IL_MASK 12'h070
`define CAM_ADDR_GEN_MASK 12'h071
`define CAM_ADDR_ID_LOW 12'h078
`define CAM_ADDR_ID_MID 12'h079
`define CAM_ADDR_ID_HIGH 12'h07a
`define CAM_ADDR_ALARM 12'h07b
`define CAM_ADDR_IL_LIVE 12'h07c
`define CAM_ADDR_GEN_LIVE 12'h07d
`define CAM_ADDR_STICKY 12'h07e
`define CAM_ADDR_SPARE 12'h07f

`define CAM_RST_MASK 8'h00
`define CAM_ID_VALUE 24'h5a3c01
`define CAM_NEAR_SHIFT 4
`define CAM_GEN_USED 5
`define CAM_STICKY_W 7

`endif

// File: rtl/cam_pkg.sv
// types of the clock alarm mask and readback block
package cam_pkg;

  // status conditions arriving from the loops, detectors and sync logic
  typedef struct packed {
    logic [3:0] los;           // loss of signal per reference input
    logic il_acquiring;
    logic il_locked;
    logic il_holdover;
    logic ol_acquiring;
    logic ol_locked;
    logic ol_disabled;
    logic sysref_valid;
    logic sync_pin_pulse;      // external sync pulse seen
    logic sync_spi_request;    // serial port sync request issued
    logic [15:0] il_lock_count;
    logic [15:0] il_lock_limit;
    logic [15:0] ol_lock_count;
    logic [15:0] ol_lock_limit;
  } cam_status_t;

  // register access port request
  typedef struct packed {
    logic [11:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } cam_reg_req_t;

  // whole state of the top module
  typedef struct packed {
    logic [7:0] il_mask;
    logic [7:0] gen_mask;
    logic synced;
    logic alarm;
    logic [7:0] rdata;
  } cam_state_t;

  // whole state of the sticky module
  typedef struct packed {
    logic [6:0] bits;
  } cam_sticky_state_t;

endpackage : cam_pkg

// File: rtl/cam_sticky.sv
// sticky status bits: set by events, zeroed by the clear event
`timescale 1ns/100ps
`default_nettype none
`include "cam_params.svh"

module cam_sticky (
  input wire logic clk_sys_in,                        // register clock
  input wire logic reset_in,                          // async reset, active high
  input wire logic [`CAM_STICKY_W-1:0] set_in,        // events to latch
  input wire logic clear_in,                          // clear event
  output logic [`CAM_STICKY_W-1:0] sticky_out         // latched record
);

  cam_pkg::cam_sticky_state_t st;
  cam_pkg::cam_sticky_state_t next_st;

  // set wins over a clear in the same cycle
  always_comb begin
    next_st = st;
    if (clear_in) begin
      next_st.bits = '0;
    end
    next_st.bits = next_st.bits | set_in;
  end

  // state register
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sticky_out = st.bits;

endmodule : cam_sticky
`default_nettype wire

// File: verification/cam_host_model.sv
// host controller model that reads and writes the alarm registers
`timescale 1ns/100ps
`default_nettype none

module cam_host_model (
  input wire logic clk_sys_in,                 // register clock
  input wire logic [7:0] reg_rdata_in,         // read data from the device
  output var cam_pkg::cam_reg_req_t reg_req_out, // register request
  output logic sticky_clear_out                // clear event for sticky bits
);
  // idle bus shows inverted old values so stale data never looks valid
  initial begin
    reg_req_out = '0;
    sticky_clear_out = 1'b0;
  end

  // one write strobe, then release
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    @(negedge clk_sys_in);
    reg_req_out = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: v};
    @(negedge clk_sys_in);
    reg_req_out = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~v};
  endtask : wr

  // one read strobe, data taken the cycle after
  task automatic rd(input logic [11:0] a, output logic [7:0] v);
    @(negedge clk_sys_in);
    reg_req_out = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(negedge clk_sys_in);
    reg_req_out = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: 8'hff};
    v = reg_rdata_in;
  endtask : rd

  // single cycle clear before sticky bits are trusted
  task automatic clear_sticky();
    @(negedge clk_sys_in);
    sticky_clear_out = 1'b1;
    @(negedge clk_sys_in);
    sticky_clear_out = 1'b0;
  endtask : clear_sticky
endmodule : cam_host_model
`default_nettype wire

// File: verification/tb.sv
// self-checking testbench of the alarm mask and readback block
`timescale 1ns/100ps
`default_nettype none
`include "cam_params.svh"

module tb;
  logic clk_sys_in;
  logic reset_in;
  cam_pkg::cam_status_t st;
  cam_pkg::cam_reg_req_t req;
  logic clr;
  logic [7:0] rdata;
  logic alarm;
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;
  logic synced_m;
  logic [6:0] sticky_m;
  logic [7:0] m1, m2, d, il, gen;
  logic [95:0] rnd;

  cam_alarm_top cam_alarm_top_inst (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
    .status_in(st), .reg_req_in(req), .sticky_clear_in(clr), .reg_rdata_out(rdata),
    .alarm_out(alarm));
  cam_host_model cam_host_model_inst (.clk_sys_in(clk_sys_in), .reg_rdata_in(rdata),
    .reg_req_out(req), .sticky_clear_out(clr));

  // 250 MHz clock
  initial begin
    clk_sys_in = 1'b0;
    forever #2 clk_sys_in = ~clk_sys_in;
  end

  // expected live registers
  function automatic logic [7:0] il_exp(input cam_pkg::cam_status_t s);
    return {s.il_lock_count >= (s.il_lock_limit >> 4), s.il_acquiring, s.il_locked,
      s.il_holdover, s.los};
  endfunction : il_exp
  function automatic logic [7:0] gen_exp(input cam_pkg::cam_status_t s, input logic sy);
    return {3'h0, (s.ol_locked | s.ol_disabled) & ~sy, s.il_locked & s.ol_locked,
      s.sysref_valid, ~sy, s.ol_lock_count >= (s.ol_lock_limit >> 4)};
  endfunction : gen_exp

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish

  // hang guard
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  // main sequence
  initial begin
    st = '0;
    reset_in = 1'b1;
    synced_m = 1'b0;
    sticky_m = 7'h00;
    void'($urandom(53231));
    repeat (6) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    reset_in = 1'b0;
    cam_host_model_inst.rd(`CAM_ADDR_IL_MASK, d);
    check(d, `CAM_RST_MASK);
    check(alarm, 1'b0);
    for (int i = 0; i < 3; i++) begin
      cam_host_model_inst.wr(`CAM_ADDR_ID_LOW + 12'(i), 8'h55);
      cam_host_model_inst.rd(`CAM_ADDR_ID_LOW + 12'(i), d);
      check(d, (`CAM_ID_VALUE >> (8 * i)) & 24'hff);
    end
    cam_host_model_inst.wr(`CAM_ADDR_SPARE, 8'hff);
    cam_host_model_inst.rd(`CAM_ADDR_SPARE, d);
    check(d, 8'h00);
    $display("test reset and ident done");
    // one-hot masks first, then random masks and status
    for (int i = 0; i < 48; i++) begin
      m1 = (i < 8) ? 8'h01 << i : (i < 13) ? 8'h00 : 8'($urandom);
      m2 = (i < 8) ? 8'h00 : (i < 13) ? 8'h01 << (i - 8) : 8'($urandom);
      cam_host_model_inst.wr(`CAM_ADDR_IL_MASK, m1);
      cam_host_model_inst.wr(`CAM_ADDR_GEN_MASK, m2);
      @(negedge clk_sys_in);
      rnd = {$urandom, $urandom, $urandom};
      st = rnd[$bits(st)-1:0];
      st.sync_pin_pulse = 1'b0;
      st.sync_spi_request = (i == 30);
      st.il_lock_count = (st.il_lock_limit >> 4) + 16'($urandom % 3) - 16'h1;
      st.ol_lock_count = (st.ol_lock_limit >> 4) + 16'($urandom % 3) - 16'h1;
      // corner case: output loop counter exactly at a sixteenth of its limit
      if (i == 20) begin
        st.ol_lock_limit = 16'h0100;
        st.ol_lock_count = 16'h0010;
      end
      synced_m |= st.sync_spi_request;
      sticky_m |= {st.ol_acquiring, st.il_acquiring, st.il_holdover, st.los};
      il = il_exp(st);
      gen = gen_exp(st, synced_m);
      repeat (2) @(negedge clk_sys_in);
      check(alarm, (|(il & m1)) | (|(gen[4:0] & m2[4:0])));
      cam_host_model_inst.rd(`CAM_ADDR_ALARM, d);
      check(d, {7'h0, (|(il & m1)) | (|(gen[4:0] & m2[4:0]))});
      cam_host_model_inst.rd(`CAM_ADDR_IL_LIVE, d);
      check(d, il);
      cam_host_model_inst.rd(`CAM_ADDR_GEN_LIVE, d);
      check(d, gen);
      cam_host_model_inst.rd(`CAM_ADDR_STICKY, d);
      check(d, {1'b0, sticky_m});
      cam_host_model_inst.rd(`CAM_ADDR_GEN_MASK, d);
      check(d, m2);
    end
    $display("test masked alarm and live status done");
    // clear, then one short holdover event
    @(negedge clk_sys_in);
    st = '0;
    cam_host_model_inst.clear_sticky();
    cam_host_model_inst.rd(`CAM_ADDR_STICKY, d);
    check(d, 8'h00);
    @(negedge clk_sys_in);
    st.il_holdover = 1'b1;
    @(negedge clk_sys_in);
    st.il_holdover = 1'b0;
    cam_host_model_inst.rd(`CAM_ADDR_STICKY, d);
    check(d, 8'h10);
    // clear while an acquisition event is held: the set wins
    st.il_acquiring = 1'b1;
    cam_host_model_inst.clear_sticky();
    st.il_acquiring = 1'b0;
    cam_host_model_inst.rd(`CAM_ADDR_STICKY, d);
    check(d, 8'h20);
    $display("test sticky clear done");
    // reset in mid-run, then an external sync pulse
    @(negedge clk_sys_in);
    reset_in = 1'b1;
    repeat (2) @(negedge clk_sys_in);
    reset_in = 1'b0;
    cam_host_model_inst.rd(`CAM_ADDR_GEN_MASK, d);
    check(d, `CAM_RST_MASK);
    cam_host_model_inst.rd(`CAM_ADDR_GEN_LIVE, d);
    check(d, gen_exp(st, 1'b0));
    st.sync_pin_pulse = 1'b1;
    @(negedge clk_sys_in);
    st.sync_pin_pulse = 1'b0;
    cam_host_model_inst.rd(`CAM_ADDR_GEN_LIVE, d);
    check(d, gen_exp(st, 1'b1));
    $display("test reset and sync pulse done");
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
